// ===== core/cpsr_parity.sv
`timescale 1ns/10ps
module cpsr_parity #(
	parameter int WIDTH = 8
) (
	// word to test
	input  wire logic [WIDTH-1:0] data,
	// high when the word holds an odd number of ones
	output logic                  odd
);

	// reduction exclusive or gives odd parity
	assign odd = ^data;

endmodule

// ===== core/cpsr_pkg.sv
package cpsr_pkg;

	// special-function register addresses
	localparam logic [7:0] SFR_PTR0_LOW   = 8'h82;
	localparam logic [7:0] SFR_PTR0_HIGH  = 8'h83;
	localparam logic [7:0] SFR_PTR1_LOW   = 8'h84;
	localparam logic [7:0] SFR_PTR1_HIGH  = 8'h85;
	localparam logic [7:0] SFR_PTR_SELECT = 8'h92;
	localparam logic [7:0] SFR_STATUS     = 8'hD0;
	localparam logic [7:0] SFR_WORK       = 8'hE0;

	// bit-address groups: upper five bits of a bit address
	localparam logic [4:0] BIT_GRP_STATUS = 5'h1A;
	localparam logic [4:0] BIT_GRP_WORK   = 5'h1C;

	// general register windows: upper eleven bits of a 16-bit address
	localparam logic [10:0] DATA_BANK_HI = 11'h000;
	localparam logic [10:0] UNI_BANK_HI  = 11'h7F8;

	// bank geometry
	localparam int GEN_REG_COUNT = 32;

	// status word field positions
	localparam int ST_CARRY  = 7;
	localparam int ST_NIBBLE = 6;
	localparam int ST_USER0  = 5;
	localparam int ST_BANK_H = 4;
	localparam int ST_BANK_L = 3;
	localparam int ST_EXCESS = 2;
	localparam int ST_USER1  = 1;
	localparam int ST_PARITY = 0;
	localparam int PSEL_BIT  = 0;

	// reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// complete register state of the block
	typedef struct packed {
		logic [15:0]                   ptr0;
		logic [15:0]                   ptr1;
		logic [7:0]                    psel;
		logic [7:0]                    cpu_status_word;
		logic [7:0]                    acc;
		logic [GEN_REG_COUNT-1:0][7:0] gen;
		logic [7:0]                    sfr_rdata;
		logic                          sfr_hit;
		logic [7:0]                    mem_rdata;
		logic                          mem_hit;
		logic                          bit_rdata;
		logic [7:0]                    rn_rdata;
		logic [15:0]                   ptr_act;
	} cpsr_state_t;

endpackage

// ===== core/cpsr_regs.sv
`timescale 1ns/10ps
module cpsr_regs import cpsr_pkg::*; (
	// clock, reset and freeze
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// special-function register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_hit,
	// single-bit access port
	input  wire logic [7:0]  bit_addr,
	input  wire logic        bit_wr,
	input  wire logic        bit_rd,
	input  wire logic        bit_wdata,
	output logic             bit_rdata,
	// data and unified memory port for the general registers
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_wr,
	input  wire logic        mem_rd,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata,
	output logic             mem_hit,
	// register-operand port through the active bank
	input  wire logic [2:0]  rn_idx,
	input  wire logic        rn_wr,
	input  wire logic        rn_rd,
	input  wire logic [7:0]  rn_wdata,
	output logic      [7:0]  rn_rdata,
	// execution results
	input  wire logic        ptr_load,
	input  wire logic [15:0] ptr_value,
	input  wire logic        acc_load,
	input  wire logic [7:0]  acc_value,
	input  wire logic        cy_upd,
	input  wire logic        cy_val,
	input  wire logic        ac_upd,
	input  wire logic        ac_val,
	input  wire logic        ov_upd,
	input  wire logic        ov_val,
	// architectural state
	output logic      [15:0] ptr_active,
	output logic      [7:0]  work_register,
	output logic      [7:0]  status_word,
	output logic      [1:0]  bank_select
);

	cpsr_state_t q;
	cpsr_state_t d;
	logic [7:0]  acc_nx;
	logic        par_nx;
	logic        sfr_w;
	logic        bit_w;
	logic        bit_st;
	logic        bit_wk;
	logic        mem_in;

	// decoded strobes
	assign sfr_w  = sfr_wr;
	assign bit_w  = bit_wr;
	assign bit_st = (bit_addr[7:3] == BIT_GRP_STATUS);
	assign bit_wk = (bit_addr[7:3] == BIT_GRP_WORK);
	assign mem_in = (mem_addr[15:5] == DATA_BANK_HI) || (mem_addr[15:5] == UNI_BANK_HI);

	// next work register value; execution load has last word
	always_comb begin
		acc_nx = q.acc;
		if (sfr_w && sfr_addr == SFR_WORK) begin
			acc_nx = sfr_wdata;
		end
		if (bit_w && bit_wk) begin
			acc_nx[bit_addr[2:0]] = bit_wdata;
		end
		if (acc_load) begin
			acc_nx = acc_value;
		end
	end

	// parity of the value the work register is about to hold
	cpsr_parity #(
		.WIDTH (8)
	) u_parity (
		.data (acc_nx),
		.odd  (par_nx)
	);

	// next-state logic for the whole block
	always_comb begin
		d         = q;
		d.sfr_hit = 1'b0;
		d.mem_hit = 1'b0;
		d.acc     = acc_nx;
		// byte writes over the register port
		if (sfr_w) begin
			unique case (sfr_addr)
				SFR_PTR0_LOW:   d.ptr0[7:0]  = sfr_wdata;
				SFR_PTR0_HIGH:  d.ptr0[15:8] = sfr_wdata;
				SFR_PTR1_LOW:   d.ptr1[7:0]  = sfr_wdata;
				SFR_PTR1_HIGH:  d.ptr1[15:8] = sfr_wdata;
				SFR_PTR_SELECT: d.psel       = sfr_wdata;
				SFR_STATUS:     d.cpu_status_word        = sfr_wdata;
				default: ;
			endcase
		end
		// single-bit writes into the status word
		if (bit_w && bit_st) begin
			d.cpu_status_word[bit_addr[2:0]] = bit_wdata;
		end
		// pointer load from execution goes to the pointer in use
		if (ptr_load) begin
			if (d.psel[PSEL_BIT]) begin
				d.ptr1 = ptr_value;
			end else begin
				d.ptr0 = ptr_value;
			end
		end
		// arithmetic results override software writes of the same cycle
		if (cy_upd) begin
			d.cpu_status_word[ST_CARRY] = cy_val;
		end
		if (ac_upd) begin
			d.cpu_status_word[ST_NIBBLE] = ac_val;
		end
		if (ov_upd) begin
			d.cpu_status_word[ST_EXCESS] = ov_val;
		end
		d.cpu_status_word[ST_PARITY] = par_nx;
		// general register writes, memory alias first then operand port
		if (mem_wr && mem_in) begin
			d.gen[mem_addr[4:0]] = mem_wdata;
		end
		if (rn_wr) begin
			d.gen[{q.cpu_status_word[ST_BANK_H:ST_BANK_L], rn_idx}] = rn_wdata;
		end
		// register port read, old contents
		if (sfr_rd) begin
			d.sfr_hit = 1'b1;
			unique case (sfr_addr)
				SFR_PTR0_LOW:   d.sfr_rdata = q.ptr0[7:0];
				SFR_PTR0_HIGH:  d.sfr_rdata = q.ptr0[15:8];
				SFR_PTR1_LOW:   d.sfr_rdata = q.ptr1[7:0];
				SFR_PTR1_HIGH:  d.sfr_rdata = q.ptr1[15:8];
				SFR_PTR_SELECT: d.sfr_rdata = q.psel;
				SFR_STATUS:     d.sfr_rdata = q.cpu_status_word;
				SFR_WORK:       d.sfr_rdata = q.acc;
				default: begin
					d.sfr_rdata = RST_BYTE;
					d.sfr_hit   = 1'b0;
				end
			endcase
		end
		// single-bit read
		if (bit_rd) begin
			if (bit_st) begin
				d.bit_rdata = q.cpu_status_word[bit_addr[2:0]];
			end else if (bit_wk) begin
				d.bit_rdata = q.acc[bit_addr[2:0]];
			end else begin
				d.bit_rdata = 1'b0;
			end
		end
		// memory read of the general registers
		if (mem_rd) begin
			d.mem_hit   = mem_in;
			d.mem_rdata = mem_in ? q.gen[mem_addr[4:0]] : RST_BYTE;
		end
		// operand read through the active bank
		if (rn_rd) begin
			d.rn_rdata = q.gen[{q.cpu_status_word[ST_BANK_H:ST_BANK_L], rn_idx}];
		end
		d.ptr_act = d.psel[PSEL_BIT] ? d.ptr1 : d.ptr0;
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// outputs straight from the state register
	assign sfr_rdata     = q.sfr_rdata;
	assign sfr_hit       = q.sfr_hit;
	assign bit_rdata     = q.bit_rdata;
	assign mem_rdata     = q.mem_rdata;
	assign mem_hit       = q.mem_hit;
	assign rn_rdata      = q.rn_rdata;
	assign ptr_active    = q.ptr_act;
	assign work_register = q.acc;
	assign status_word   = q.cpu_status_word;
	assign bank_select   = q.cpu_status_word[ST_BANK_H:ST_BANK_L];

	// active pointer always follows the select bit
	property p_ptr_follow;
		@(posedge core_clk) disable iff (!rst_n)
		ptr_active == (q.psel[PSEL_BIT] ? q.ptr1 : q.ptr0);
	endproperty
	a_ptr_follow: assert property (p_ptr_follow) else $error("active pointer mismatch");

	// high byte write to pointer zero lands without touching the low byte
	property p_ptr0_high;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && sfr_wr && sfr_addr == SFR_PTR0_HIGH && !ptr_load)
		|=> (q.ptr0[15:8] == $past(sfr_wdata)) && $stable(q.ptr0[7:0]);
	endproperty
	a_ptr0_high: assert property (p_ptr0_high) else $error("pointer byte write wrong");

	// unused select bits keep what software wrote, read back after one quiet cycle
	property p_psel_keep;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && sfr_wr && sfr_addr == SFR_PTR_SELECT)
		##1 !(sfr_wr && sfr_addr == SFR_PTR_SELECT)
		##1 (clk_en && sfr_rd && sfr_addr == SFR_PTR_SELECT)
		|=> sfr_rdata == $past(sfr_wdata, 3);
	endproperty
	a_psel_keep: assert property (p_psel_keep) else $error("select readback wrong");

	// parity flag always matches the work register
	property p_parity;
		@(posedge core_clk) disable iff (!rst_n)
		status_word[ST_PARITY] == ^work_register;
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag wrong");

	// carry update takes the arithmetic result
	property p_carry;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && cy_upd) |=> status_word[ST_CARRY] == $past(cy_val);
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag not updated");

	// nibble carry update takes the arithmetic result
	property p_nibble;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && ac_upd) |=> status_word[ST_NIBBLE] == $past(ac_val);
	endproperty
	a_nibble: assert property (p_nibble) else $error("nibble carry not updated");

	// excess flag update takes the arithmetic result
	property p_excess;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && ov_upd) |=> status_word[ST_EXCESS] == $past(ov_val);
	endproperty
	a_excess: assert property (p_excess) else $error("excess flag not updated");

	// software carry write holds while no arithmetic touches it
	property p_flag_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && sfr_wr && sfr_addr == SFR_STATUS && !cy_upd && !bit_wr)
		##1 (!cy_upd && !sfr_wr && !bit_wr)
		|=> status_word[ST_CARRY] == $past(sfr_wdata[ST_CARRY], 2);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("written flag lost");

	// a status word write picks the bank from its bits 4:3
	property p_bank;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && sfr_wr && sfr_addr == SFR_STATUS && !bit_wr)
		|=> bank_select == $past(sfr_wdata[ST_BANK_H:ST_BANK_L]);
	endproperty
	a_bank: assert property (p_bank) else $error("bank select mismatch");

	// unified and data windows both answer
	property p_alias_hit;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && mem_rd && (mem_addr[15:5] == UNI_BANK_HI || mem_addr[15:5] == DATA_BANK_HI))
		|=> mem_hit;
	endproperty
	a_alias_hit: assert property (p_alias_hit) else $error("bank window missed");

	// work register write over the register port
	property p_work_wr;
		@(posedge core_clk) disable iff (!rst_n)
		(clk_en && sfr_wr && sfr_addr == SFR_WORK && !acc_load && !bit_wr)
		|=> work_register == $past(sfr_wdata);
	endproperty
	a_work_wr: assert property (p_work_wr) else $error("work register write lost");

	// a frozen cycle changes nothing
	property p_freeze;
		@(posedge core_clk) disable iff (!rst_n)
		!clk_en |=> $stable(status_word) && $stable(ptr_active) && $stable(work_register);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule

// ===== test/cpsr_exec_model.sv
`timescale 1ns/10ps
module cpsr_exec_model (
	// clock
	input  wire logic        core_clk,
	// register and bit ports
	output logic      [7:0]  sfr_addr,
	output logic             sfr_wr,
	output logic             sfr_rd,
	output logic      [7:0]  sfr_wdata,
	output logic      [7:0]  bit_addr,
	output logic             bit_wr,
	output logic             bit_rd,
	output logic             bit_wdata,
	// memory and operand ports
	output logic      [15:0] mem_addr,
	output logic             mem_wr,
	output logic             mem_rd,
	output logic      [7:0]  mem_wdata,
	output logic      [2:0]  rn_idx,
	output logic             rn_wr,
	output logic             rn_rd,
	output logic      [7:0]  rn_wdata,
	// execution results
	output logic             ptr_load,
	output logic      [15:0] ptr_value,
	output logic             acc_load,
	output logic      [7:0]  acc_value,
	output logic             cy_upd,
	output logic             cy_val,
	output logic             ac_upd,
	output logic             ac_val,
	output logic             ov_upd,
	output logic             ov_val
);

	// drop every strobe and scramble released lines so stale values never look valid
	task automatic quiet();
		{sfr_wr, sfr_rd, bit_wr, bit_rd, mem_wr, mem_rd, rn_wr, rn_rd} = 8'h00;
		{ptr_load, acc_load, cy_upd, ac_upd, ov_upd} = 5'h00;
		{sfr_addr, sfr_wdata, bit_addr, bit_wdata} = ~{sfr_addr, sfr_wdata, bit_addr, bit_wdata};
		{mem_addr, mem_wdata, rn_idx, rn_wdata} = ~{mem_addr, mem_wdata, rn_idx, rn_wdata};
		{ptr_value, acc_value, cy_val, ac_val, ov_val} = ~{ptr_value, acc_value, cy_val, ac_val, ov_val};
	endtask

	// defined levels from time zero
	initial begin
		{sfr_addr, sfr_wdata, bit_addr, bit_wdata, mem_addr, mem_wdata} = '0;
		{rn_idx, rn_wdata, ptr_value, acc_value, cy_val, ac_val, ov_val} = '0;
		quiet();
	end

	// one access held across a single rising edge; p picks the port
	task automatic req(input int p, input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk);
		case (p)
			0: {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a[7:0], d, w, !w};
			1: {bit_addr, bit_wdata, bit_wr, bit_rd} = {a[7:0], d[0], w, !w};
			2: {mem_addr, mem_wdata, mem_wr, mem_rd} = {a, d, w, !w};
			default: {rn_idx, rn_wdata, rn_wr, rn_rd} = {a[2:0], d, w, !w};
		endcase
		@(negedge core_clk);
		quiet();
	endtask

	// one execution result; c packs the five load and update controls with the three flag values
	task automatic ex(input logic [7:0] c, input logic [15:0] pv, input logic [7:0] av);
		@(negedge core_clk);
		{ptr_load, acc_load, cy_upd, cy_val, ac_upd, ac_val, ov_upd, ov_val} = c;
		ptr_value = pv;
		acc_value = av;
		@(negedge core_clk);
		quiet();
	endtask

endmodule

// ===== test/tb_cpu_pointer_status_regs.sv
`timescale 1ns/10ps
module tb_cpu_pointer_status_regs import cpsr_pkg::*; ;
	// clock, reset, freeze and request lines
	logic        core_clk, rst_n, clk_en;
	logic [7:0]  sfr_addr, sfr_wdata, bit_addr, mem_wdata, rn_wdata, acc_value;
	logic [15:0] mem_addr, ptr_value;
	logic [2:0]  rn_idx;
	logic        sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, mem_wr, mem_rd, rn_wr, rn_rd;
	logic        ptr_load, acc_load, cy_upd, cy_val, ac_upd, ac_val, ov_upd, ov_val;
	// block outputs and tallies
	logic [7:0]  sfr_rdata, mem_rdata, rn_rdata, work_register, status_word;
	logic [15:0] ptr_active;
	logic [1:0]  bank_select;
	logic        sfr_hit, bit_rdata, mem_hit;
	int          mismatches = 0;
	int          comparisons = 0;

	cpsr_regs i_dut (.core_clk, .rst_n, .clk_en, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata, .sfr_hit, .bit_addr, .bit_wr, .bit_rd, .bit_wdata, .bit_rdata,
		.mem_addr, .mem_wr, .mem_rd, .mem_wdata, .mem_rdata, .mem_hit, .rn_idx, .rn_wr,
		.rn_rd, .rn_wdata, .rn_rdata, .ptr_load, .ptr_value, .acc_load, .acc_value,
		.cy_upd, .cy_val, .ac_upd, .ac_val, .ov_upd, .ov_val, .ptr_active,
		.work_register, .status_word, .bank_select);
	cpsr_exec_model i_exec (.core_clk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .bit_addr,
		.bit_wr, .bit_rd, .bit_wdata, .mem_addr, .mem_wr, .mem_rd, .mem_wdata, .rn_idx,
		.rn_wr, .rn_rd, .rn_wdata, .ptr_load, .ptr_value, .acc_load, .acc_value, .cy_upd,
		.cy_val, .ac_upd, .ac_val, .ov_upd, .ov_val);

	// compare one value and count the outcome
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	// print the verdict and end the run
	task automatic report_and_stop();
		if (mismatches == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// register write, and register read with compare
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_exec.req(0, 1'b1, 16'(a), d);
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
		i_exec.req(0, 1'b0, 16'(a), 8'h00);
		chk(n, 16'(e), 16'(sfr_rdata));
		chk("sfr_hit", 16'h0001, 16'(sfr_hit));
	endtask

	// everything reads zero after reset
	task automatic t_reset();
		logic [7:0] regs[7] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h92, 8'hD0, 8'hE0};
		chk("status_word", 16'h0000, 16'(status_word));
		chk("ptr_active", 16'h0000, ptr_active);
		foreach (regs[i]) rdc("reset value", regs[i], RST_BYTE);
	endtask

	// byte access to both pointers, select bit and pointer load
	task automatic t_ptr();
		wr(8'h82, 8'h34);
		wr(8'h83, 8'h12);
		wr(8'h84, 8'h78);
		wr(8'h85, 8'h56);
		chk("ptr_active", 16'h1234, ptr_active);
		wr(8'h92, 8'hFF);
		chk("ptr_active", 16'h5678, ptr_active);
		rdc("pointer_select", 8'h92, 8'hFF);
		rdc("pointer0_high", 8'h83, 8'h12);
		i_exec.ex(8'h80, 16'hBEEF, 8'h00);
		rdc("pointer1_low", 8'h84, 8'hEF);
		rdc("pointer0_low", 8'h82, 8'h34);
		wr(8'h92, 8'hFE);
		chk("ptr_active", 16'h1234, ptr_active);
		i_exec.ex(8'h80, 16'hCAFE, 8'h00);
		chk("ptr_active", 16'hCAFE, ptr_active);
	endtask

	// each bank through the operand port, both memory windows and a miss
	task automatic t_banks();
		for (int b = 0; b < 4; b++) begin
			wr(8'hD0, 8'(b << 3));
			chk("bank_select", 16'(b), 16'(bank_select));
			i_exec.req(3, 1'b1, 16'h0005, 8'(8'h40 + b));
			i_exec.req(2, 1'b0, 16'(b * 8 + 5), 8'h00);
			chk("data window", 16'(8'h40 + b), 16'(mem_rdata));
			chk("mem_hit", 16'h0001, 16'(mem_hit));
			i_exec.req(2, 1'b0, 16'(16'hFF05 + b * 8), 8'h00);
			chk("unified window", 16'(8'h40 + b), 16'(mem_rdata));
		end
		i_exec.req(2, 1'b1, 16'hFF1F, 8'hA5);
		i_exec.req(3, 1'b0, 16'h0007, 8'h00);
		chk("top register", 16'h00A5, 16'(rn_rdata));
		i_exec.req(2, 1'b1, 16'h0018, 8'h5A);
		i_exec.req(3, 1'b0, 16'h0000, 8'h00);
		chk("bank 3 first register", 16'h005A, 16'(rn_rdata));
		i_exec.req(2, 1'b0, 16'h0020, 8'h00);
		chk("miss hit", 16'h0000, 16'(mem_hit));
		wr(8'hD0, 8'h00);
	endtask

	// arithmetic flags, user flags, bit access and parity
	task automatic t_flags();
		i_exec.ex(8'h40, 16'h0000, 8'h07);
		chk("work_register", 16'h0007, 16'(work_register));
		chk("status_word", 16'h0001, 16'(status_word));
		rdc("work_register", 8'hE0, 8'h07);
		i_exec.ex(8'h3F, 16'h0000, 8'h00);
		chk("status_word", 16'h00C5, 16'(status_word));
		i_exec.ex(8'h20, 16'h0000, 8'h00);
		chk("status_word", 16'h0045, 16'(status_word));
		wr(8'hD0, 8'hA6);
		chk("status_word", 16'h00A7, 16'(status_word));
		i_exec.req(1, 1'b1, 16'h00D5, 8'h00);
		i_exec.req(1, 1'b1, 16'h00D0, 8'h00);
		chk("status_word", 16'h0087, 16'(status_word));
		i_exec.req(1, 1'b1, 16'h00E0, 8'h00);
		chk("status_word", 16'h0086, 16'(status_word));
		i_exec.req(1, 1'b0, 16'h00D7, 8'h00);
		chk("status bit", 16'h0001, 16'(bit_rdata));
		i_exec.req(1, 1'b0, 16'h00E1, 8'h00);
		chk("work bit", 16'h0001, 16'(bit_rdata));
		rdc("cpu_status_word", 8'hD0, 8'h86);
	endtask

	// a low clock enable freezes the registers
	task automatic t_freeze();
		clk_en = 1'b0;
		wr(8'hE0, 8'hFF);
		chk("work_register", 16'h0006, 16'(work_register));
		clk_en = 1'b1;
		wr(8'hE0, 8'hFF);
		chk("status_word", 16'h0086, 16'(status_word));
		rdc("work_register", 8'hE0, 8'hFF);
	endtask

	// free-running clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// reset, scenarios and verdict
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		t_reset();
		t_ptr();
		t_banks();
		t_flags();
		t_freeze();
		report_and_stop();
	end

	// watchdog, far beyond the roughly 110 cycles the scenarios need
	initial begin
		#(1000 * 100);
		mismatches++;
		report_and_stop();
	end

endmodule
